//--- verilog/ddcc_pkg.sv
// Package of register offsets, field layouts and reset values for the channel filter configuration
package ddcc_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int DDCC_ADDR_W      = 8;
	localparam int DDCC_DATA_W      = 20;
	localparam int DDCC_PHASE_W     = 16;
	localparam int DDCC_OSC_CTRL_W  = 9;
	localparam int DDCC_RDEC_W      = 12;
	localparam int DDCC_RINT_W      = 9;
	localparam int DDCC_RSCL_W      = 12;
	localparam int DDCC_SCL5_W      = 5;
	localparam int DDCC_BYTE_W      = 8;
	localparam int DDCC_CCTL_W      = 11;
	localparam int DDCC_OSCALE_W    = 4;
	localparam int DDCC_SIG_W       = 16;
	localparam int DDCC_SYNC_PINS   = 4;

	// ------------------------------------------------------------
	// Channel address map
	// ------------------------------------------------------------
	localparam logic [7:0] DDCC_OFS_COEFFICIENT_MEMORY_LAST = 8'h7F;
	localparam logic [7:0] DDCC_OFS_PHASE     = 8'h87;
	localparam logic [7:0] DDCC_OFS_OSC_CTRL  = 8'h88;
	localparam logic [7:0] DDCC_OFS_RDEC      = 8'h90;
	localparam logic [7:0] DDCC_OFS_RINT      = 8'h91;
	localparam logic [7:0] DDCC_OFS_RSCL      = 8'h92;
	localparam logic [7:0] DDCC_OFS_RSV_A     = 8'h93;
	localparam logic [7:0] DDCC_OFS_FDEC      = 8'h94;
	localparam logic [7:0] DDCC_OFS_FSCL      = 8'h95;
	localparam logic [7:0] DDCC_OFS_RSV_B     = 8'h96;
	localparam logic [7:0] DDCC_OFS_CDEC      = 8'hA0;
	localparam logic [7:0] DDCC_OFS_CPHASE    = 8'hA1;
	localparam logic [7:0] DDCC_OFS_CTAPS     = 8'hA2;
	localparam logic [7:0] DDCC_OFS_COFS      = 8'hA3;
	localparam logic [7:0] DDCC_OFS_CCTL      = 8'hA4;
	localparam logic [7:0] DDCC_OFS_SIG_I     = 8'hA5;
	localparam logic [7:0] DDCC_OFS_SIG_Q     = 8'hA6;

	// ------------------------------------------------------------
	// Oscillator control fields
	// ------------------------------------------------------------
	localparam int DDCC_OSC_SYNC_LSB  = 7;
	localparam int DDCC_OSC_INSEL     = 6;
	localparam int DDCC_OSC_CLR_HOP   = 3;
	localparam int DDCC_OSC_AMP_DITH  = 2;
	localparam int DDCC_OSC_PH_DITH   = 1;
	localparam int DDCC_OSC_BYPASS    = 0;
	localparam logic [8:0] DDCC_OSC_CTRL_MASK = 9'h1CF;

	// ------------------------------------------------------------
	// Resampler scale fields
	// ------------------------------------------------------------
	localparam int DDCC_RSCL_LOUD_LSB  = 0;
	localparam int DDCC_RSCL_QUIET_LSB = 5;
	localparam logic [11:0] DDCC_RSCL_MASK = 12'h03FF;

	// ------------------------------------------------------------
	// Coefficient filter control fields
	// ------------------------------------------------------------
	localparam int DDCC_CCTL_BYPASS  = 10;
	localparam int DDCC_CCTL_INSRC   = 9;
	localparam int DDCC_CCTL_BANK    = 8;
	localparam int DDCC_CCTL_COMEXP  = 7;
	localparam int DDCC_CCTL_FORCE   = 6;
	localparam int DDCC_CCTL_FMT_HI  = 5;
	localparam int DDCC_CCTL_FMT_LO  = 4;
	localparam int DDCC_CCTL_SCL_LSB = 0;
	localparam logic [4:0] DDCC_OSCALE_BIAS = 5'h03;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] DDCC_RST_PHASE = 16'h0000;
	localparam logic [8:0]  DDCC_RST_OSC   = 9'h000;
	localparam logic [11:0] DDCC_RST_RDEC  = 12'h000;
	localparam logic [8:0]  DDCC_RST_RINT  = 9'h000;
	localparam logic [11:0] DDCC_RST_RSCL  = 12'h000;
	localparam logic [4:0]  DDCC_RST_SCL5  = 5'h00;
	localparam logic [7:0]  DDCC_RST_BYTE  = 8'h00;
	localparam logic [10:0] DDCC_RST_CCTL  = 11'h000;
	localparam logic [15:0] DDCC_RST_SIG   = 16'h0000;
	localparam logic [19:0] DDCC_RST_DATA  = 20'h0_0000;

	// Output encoding of the coefficient filter
	typedef enum logic [1:0] {DDCC_FMT_FIXED, DDCC_FMT_FLOAT8, DDCC_FMT_FLOAT12} ddcc_fmt_type;

endpackage

//--- verilog/ddcc_plus_one.sv
// Registered conversion of a stored ratio-minus-one field into the effective ratio
`timescale 1ns/1ps
module ddcc_plus_one #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] value,
	output logic      [W:0]   ratio
);
	localparam logic [W:0] RATIO_RESET = (W+1)'(1);
	localparam logic [W:0] RATIO_STEP  = (W+1)'(1);

	// Effective ratio is stored value plus one
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ratio <= RATIO_RESET;
		end else begin
			ratio <= {1'b0, value} + RATIO_STEP;
		end
	end
endmodule

//--- verilog/ddcc_channel_cfg.sv
// Per-channel oscillator and filter configuration register set with its datapath steering
// What this block does
// RULE1 - Phase offset added to accumulator upper half
// RULE2 - Two-bit field picks sync pin A-D
// RULE3 - Input select bit picks port A/B
// RULE4 - Software writes zeros to reserved bits
// RULE5 - Clear-on-hop bit zeroes accumulator on hop
// RULE6 - Dither bits enable phase and amplitude dither
// RULE7 - Bypass sends A to I, B to Q
// RULE8 - Resampler decimation stored minus one, 1-4096
// RULE9 - Software keeps decimation above interpolation
// RULE10 - Resampler interpolation stored minus one, 1-512
// RULE11 - Level indicator chooses loud or quiet scale
// RULE12 - Fifth-order decimation minus one, 5-bit scale
// RULE13 - Coefficient filter decimation minus one, to 256
// RULE14 - Decimation phase loaded at start, kept on sync
// RULE15 - Tap count is register plus one
// RULE16 - Shadowed pointer loads at each output sample
// RULE17 - Filter bypass routes fifth-order data to signature
// RULE18 - Input source picks own or partner channel
// RULE19 - Bank bit extends coefficient write address
// RULE20 - Common exponent and forced scale options
// RULE21 - Two-bit field selects output encoding
// RULE22 - Fixed or forced scale shifts by field minus three
`timescale 1ns/1ps
module ddcc_channel_cfg
	import ddcc_pkg::*;
#(
	parameter int CHANNEL_INDEX = 0,
	parameter int IN_W          = 16,
	parameter int FIFTH_W       = 20
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic [DDCC_ADDR_W-1:0]   ch_addr,
	input  wire logic [DDCC_DATA_W-1:0]   ch_wdata,
	input  wire logic                     ch_wr,
	input  wire logic                     ch_rd,
	output logic      [DDCC_DATA_W-1:0]   ch_rdata,
	output logic                          coefficient_memory_wr_en,
	output logic      [DDCC_ADDR_W-1:0]   coefficient_memory_wr_addr,
	output logic      [DDCC_DATA_W-1:0]   coefficient_memory_wr_data,
	input  wire logic [DDCC_PHASE_W-1:0]  osc_acc_upper,
	output logic      [DDCC_PHASE_W-1:0]  osc_phase_angle,
	input  wire logic [DDCC_SYNC_PINS-1:0] sync_pins,
	output logic                          sync_selected,
	input  wire logic                     hop_pulse,
	output logic                          osc_acc_clear,
	output logic                          phase_dither_en,
	output logic                          amp_dither_en,
	input  wire logic [IN_W-1:0]          adc_a,
	input  wire logic [IN_W-1:0]          adc_b,
	input  wire logic [IN_W-1:0]          mixer_i,
	input  wire logic [IN_W-1:0]          mixer_q,
	output logic      [IN_W-1:0]          mixer_in,
	output logic      [IN_W-1:0]          path_i,
	output logic      [IN_W-1:0]          path_q,
	output logic      [DDCC_RDEC_W:0]     resampler_decimation,
	output logic      [DDCC_RINT_W:0]     resampler_interpolation,
	input  wire logic                     level_indicator,
	output logic      [DDCC_SCL5_W-1:0]   resampler_scale_active,
	output logic      [DDCC_BYTE_W:0]     fifth_order_decimation,
	output logic      [DDCC_SCL5_W-1:0]   fifth_order_scale,
	output logic      [DDCC_BYTE_W:0]     coef_filter_decimation,
	input  wire logic                     coef_filter_start,
	output logic      [DDCC_BYTE_W-1:0]   coef_filter_phase,
	output logic      [DDCC_BYTE_W:0]     coef_filter_taps,
	input  wire logic                     coef_filter_out_strobe,
	output logic      [DDCC_BYTE_W-1:0]   coef_filter_pointer,
	input  wire logic                     fifth_out_strobe,
	input  wire logic [FIFTH_W-1:0]       fifth_own_i,
	input  wire logic [FIFTH_W-1:0]       fifth_own_q,
	input  wire logic [FIFTH_W-1:0]       fifth_ch0_i,
	input  wire logic [FIFTH_W-1:0]       fifth_ch0_q,
	input  wire logic [FIFTH_W-1:0]       fifth_ch1_i,
	input  wire logic [FIFTH_W-1:0]       fifth_ch1_q,
	output logic      [FIFTH_W-1:0]       coef_in_i,
	output logic      [FIFTH_W-1:0]       coef_in_q,
	output logic                          coef_filter_bypass,
	input  wire logic [DDCC_SIG_W-1:0]    formatted_i,
	input  wire logic [DDCC_SIG_W-1:0]    formatted_q,
	input  wire logic                     map_to_selftest,
	output logic                          out_common_exp,
	output logic                          out_force_scale,
	output ddcc_fmt_type                  out_format,
	output logic                          out_use_scale,
	output logic signed [DDCC_SCL5_W-1:0] out_shift
);

	// ------------------------------------------------------------
	// Stored registers
	// ------------------------------------------------------------
	logic [DDCC_PHASE_W-1:0]    phase_offset_q;
	logic [DDCC_OSC_CTRL_W-1:0] osc_ctrl_q;
	logic [DDCC_RDEC_W-1:0]     rdec_q;
	logic [DDCC_RINT_W-1:0]     rint_q;
	logic [DDCC_RSCL_W-1:0]     rscl_q;
	logic [DDCC_BYTE_W-1:0]     fdec_q;
	logic [DDCC_SCL5_W-1:0]     fscl_q;
	logic [DDCC_BYTE_W-1:0]     cdec_q;
	logic [DDCC_BYTE_W-1:0]     cphase_q;
	logic [DDCC_BYTE_W-1:0]     ctaps_q;
	logic [DDCC_BYTE_W-1:0]     cofs_shadow_q;
	logic [DDCC_CCTL_W-1:0]     cctl_q;
	logic [DDCC_SIG_W-1:0]      sig_i_q;
	logic [DDCC_SIG_W-1:0]      sig_q_q;

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	wire logic wr_phase   = ch_wr && (ch_addr == DDCC_OFS_PHASE);
	wire logic wr_osc     = ch_wr && (ch_addr == DDCC_OFS_OSC_CTRL);
	wire logic wr_rdec    = ch_wr && (ch_addr == DDCC_OFS_RDEC);
	wire logic wr_rint    = ch_wr && (ch_addr == DDCC_OFS_RINT);
	wire logic wr_rscl    = ch_wr && (ch_addr == DDCC_OFS_RSCL);
	wire logic wr_fdec    = ch_wr && (ch_addr == DDCC_OFS_FDEC);
	wire logic wr_fscl    = ch_wr && (ch_addr == DDCC_OFS_FSCL);
	wire logic wr_cdec    = ch_wr && (ch_addr == DDCC_OFS_CDEC);
	wire logic wr_cphase  = ch_wr && (ch_addr == DDCC_OFS_CPHASE);
	wire logic wr_ctaps   = ch_wr && (ch_addr == DDCC_OFS_CTAPS);
	wire logic wr_cofs    = ch_wr && (ch_addr == DDCC_OFS_COFS);
	wire logic wr_cctl    = ch_wr && (ch_addr == DDCC_OFS_CCTL);
	wire logic wr_coefficient_memory    = ch_wr && (ch_addr <= DDCC_OFS_COEFFICIENT_MEMORY_LAST);

	// Reserved bits are dropped on write, so they always read back low
	wire logic [DDCC_OSC_CTRL_W-1:0] osc_wval  = ch_wdata[DDCC_OSC_CTRL_W-1:0] & DDCC_OSC_CTRL_MASK; // RULE4
	wire logic [DDCC_RSCL_W-1:0]     rscl_wval = ch_wdata[DDCC_RSCL_W-1:0] & DDCC_RSCL_MASK; // RULE4

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_offset_q <= DDCC_RST_PHASE;
			osc_ctrl_q     <= DDCC_RST_OSC;
			rdec_q         <= DDCC_RST_RDEC;
			rint_q         <= DDCC_RST_RINT;
			rscl_q         <= DDCC_RST_RSCL;
		end else begin
			if (wr_phase) phase_offset_q <= ch_wdata[DDCC_PHASE_W-1:0];
			if (wr_osc)   osc_ctrl_q     <= osc_wval;
			if (wr_rdec)  rdec_q         <= ch_wdata[DDCC_RDEC_W-1:0]; // RULE8
			if (wr_rint)  rint_q         <= ch_wdata[DDCC_RINT_W-1:0]; // RULE10
			if (wr_rscl)  rscl_q         <= rscl_wval;
		end
	end

	// Filter chain registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fdec_q        <= DDCC_RST_BYTE;
			fscl_q        <= DDCC_RST_SCL5;
			cdec_q        <= DDCC_RST_BYTE;
			cphase_q      <= DDCC_RST_BYTE;
			ctaps_q       <= DDCC_RST_BYTE;
			cofs_shadow_q <= DDCC_RST_BYTE;
			cctl_q        <= DDCC_RST_CCTL;
		end else begin
			if (wr_fdec)   fdec_q        <= ch_wdata[DDCC_BYTE_W-1:0]; // RULE12
			if (wr_fscl)   fscl_q        <= ch_wdata[DDCC_SCL5_W-1:0]; // RULE12
			if (wr_cdec)   cdec_q        <= ch_wdata[DDCC_BYTE_W-1:0]; // RULE13
			if (wr_cphase) cphase_q      <= ch_wdata[DDCC_BYTE_W-1:0];
			if (wr_ctaps)  ctaps_q       <= ch_wdata[DDCC_BYTE_W-1:0]; // RULE15
			if (wr_cofs)   cofs_shadow_q <= ch_wdata[DDCC_BYTE_W-1:0]; // RULE16
			if (wr_cctl)   cctl_q        <= ch_wdata[DDCC_CCTL_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Coefficient memory write port
	// ------------------------------------------------------------
	wire logic [DDCC_ADDR_W-1:0] coefficient_memory_addr_d = {cctl_q[DDCC_CCTL_BANK], ch_addr[DDCC_ADDR_W-2:0]}; // RULE19

	// Registered write strobe towards the coefficient memory
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coefficient_memory_wr_en   <= 1'b0;
			coefficient_memory_wr_addr <= DDCC_RST_BYTE;
			coefficient_memory_wr_data <= DDCC_RST_DATA;
		end else begin
			coefficient_memory_wr_en <= wr_coefficient_memory;
			if (wr_coefficient_memory) begin
				coefficient_memory_wr_addr <= coefficient_memory_addr_d; // RULE19
				coefficient_memory_wr_data <= ch_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Oscillator controls
	// ------------------------------------------------------------
	wire logic [1:0] sync_sel    = osc_ctrl_q[DDCC_OSC_SYNC_LSB +: 2];
	wire logic       in_port_b   = osc_ctrl_q[DDCC_OSC_INSEL];
	wire logic       clr_on_hop  = osc_ctrl_q[DDCC_OSC_CLR_HOP];
	wire logic       osc_bypass  = osc_ctrl_q[DDCC_OSC_BYPASS];

	assign sync_selected   = sync_pins[sync_sel]; // RULE2
	assign phase_dither_en = osc_ctrl_q[DDCC_OSC_PH_DITH]; // RULE6
	assign amp_dither_en   = osc_ctrl_q[DDCC_OSC_AMP_DITH]; // RULE6

	// Phase angle, hop clear and path routing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			osc_phase_angle <= DDCC_RST_PHASE;
			osc_acc_clear   <= 1'b0;
			mixer_in        <= '0;
			path_i          <= '0;
			path_q          <= '0;
		end else begin
			osc_phase_angle <= osc_acc_upper + phase_offset_q; // RULE1
			osc_acc_clear   <= hop_pulse && clr_on_hop; // RULE5
			mixer_in        <= in_port_b ? adc_b : adc_a; // RULE3
			path_i          <= osc_bypass ? adc_a : mixer_i; // RULE7
			path_q          <= osc_bypass ? adc_b : mixer_q; // RULE7
		end
	end

	// ------------------------------------------------------------
	// Resampler, fifth-order and coefficient filter ratios
	// ------------------------------------------------------------
	ddcc_plus_one #(.W(DDCC_RDEC_W)) u_rdec (
		.clk   (clk),
		.rst_n (rst_n),
		.value (rdec_q),
		.ratio (resampler_decimation)
	);

	ddcc_plus_one #(.W(DDCC_RINT_W)) u_rint (
		.clk   (clk),
		.rst_n (rst_n),
		.value (rint_q),
		.ratio (resampler_interpolation)
	);

	ddcc_plus_one #(.W(DDCC_BYTE_W)) u_fdec (
		.clk   (clk),
		.rst_n (rst_n),
		.value (fdec_q),
		.ratio (fifth_order_decimation)
	);

	ddcc_plus_one #(.W(DDCC_BYTE_W)) u_cdec (
		.clk   (clk),
		.rst_n (rst_n),
		.value (cdec_q),
		.ratio (coef_filter_decimation)
	);

	ddcc_plus_one #(.W(DDCC_BYTE_W)) u_ctaps (
		.clk   (clk),
		.rst_n (rst_n),
		.value (ctaps_q),
		.ratio (coef_filter_taps)
	);

	// Active resampler scale follows the level indicator
	wire logic [DDCC_SCL5_W-1:0] scale_loud  = rscl_q[DDCC_RSCL_LOUD_LSB +: DDCC_SCL5_W];
	wire logic [DDCC_SCL5_W-1:0] scale_quiet = rscl_q[DDCC_RSCL_QUIET_LSB +: DDCC_SCL5_W];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			resampler_scale_active <= DDCC_RST_SCL5;
			fifth_order_scale      <= DDCC_RST_SCL5;
		end else begin
			resampler_scale_active <= level_indicator ? scale_quiet : scale_loud; // RULE11
			fifth_order_scale      <= fscl_q; // RULE12
		end
	end

	// ------------------------------------------------------------
	// Coefficient filter phase and pointer
	// ------------------------------------------------------------
	// Phase is reloaded only at a filter start; a sync leaves it alone
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coef_filter_phase   <= DDCC_RST_BYTE;
			coef_filter_pointer <= DDCC_RST_BYTE;
		end else begin
			if (coef_filter_start) coef_filter_phase <= cphase_q; // RULE14
			if (coef_filter_out_strobe) coef_filter_pointer <= cofs_shadow_q; // RULE16
		end
	end

	// ------------------------------------------------------------
	// Coefficient filter input source
	// ------------------------------------------------------------
	localparam int PARTNER_CH = (CHANNEL_INDEX == 1) ? 0 : 1;

	wire logic             use_other = cctl_q[DDCC_CCTL_INSRC];
	wire logic [FIFTH_W-1:0] other_i = (PARTNER_CH == 0) ? fifth_ch0_i : fifth_ch1_i; // RULE18
	wire logic [FIFTH_W-1:0] other_q = (PARTNER_CH == 0) ? fifth_ch0_q : fifth_ch1_q; // RULE18

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			coef_in_i <= '0;
			coef_in_q <= '0;
		end else begin
			coef_in_i <= use_other ? other_i : fifth_own_i; // RULE18
			coef_in_q <= use_other ? other_q : fifth_own_q; // RULE18
		end
	end

	// ------------------------------------------------------------
	// Signature capture, readable only when mapped to self-test
	// ------------------------------------------------------------
	assign coef_filter_bypass = cctl_q[DDCC_CCTL_BYPASS];

	wire logic sig_take_fifth = coef_filter_bypass && fifth_out_strobe; // RULE17
	wire logic sig_take_coef  = !coef_filter_bypass && coef_filter_out_strobe;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sig_i_q <= DDCC_RST_SIG;
			sig_q_q <= DDCC_RST_SIG;
		end else if (sig_take_fifth) begin
			sig_i_q <= fifth_own_i[FIFTH_W-1 -: DDCC_SIG_W]; // RULE17
			sig_q_q <= fifth_own_q[FIFTH_W-1 -: DDCC_SIG_W]; // RULE17
		end else if (sig_take_coef) begin
			sig_i_q <= formatted_i;
			sig_q_q <= formatted_q;
		end
	end

	// ------------------------------------------------------------
	// Output formatting controls
	// ------------------------------------------------------------
	wire logic [1:0]               fmt_bits = cctl_q[DDCC_CCTL_FMT_HI:DDCC_CCTL_FMT_LO];
	wire logic [DDCC_OSCALE_W-1:0] oscale   = cctl_q[DDCC_CCTL_SCL_LSB +: DDCC_OSCALE_W];

	// 1x is the wide float, 01 the narrow float, 00 fixed point
	assign out_format      = fmt_bits[1] ? DDCC_FMT_FLOAT12 :
	                         (fmt_bits[0] ? DDCC_FMT_FLOAT8 : DDCC_FMT_FIXED); // RULE21
	assign out_common_exp  = cctl_q[DDCC_CCTL_COMEXP] && (out_format != DDCC_FMT_FIXED); // RULE20
	assign out_force_scale = cctl_q[DDCC_CCTL_FORCE]; // RULE20
	assign out_use_scale   = (out_format == DDCC_FMT_FIXED) || out_force_scale; // RULE22
	// Each step is one bit of shift, i.e. about 6.02 dB
	assign out_shift       = $signed({1'b0, oscale}) - $signed(DDCC_OSCALE_BIAS); // RULE22

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [DDCC_DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = DDCC_RST_DATA;
		unique case (ch_addr)
			DDCC_OFS_PHASE:    rd_mux = DDCC_DATA_W'(phase_offset_q);
			DDCC_OFS_OSC_CTRL: rd_mux = DDCC_DATA_W'(osc_ctrl_q);
			DDCC_OFS_RDEC:     rd_mux = DDCC_DATA_W'(rdec_q);
			DDCC_OFS_RINT:     rd_mux = DDCC_DATA_W'(rint_q);
			DDCC_OFS_RSCL:     rd_mux = DDCC_DATA_W'(rscl_q);
			DDCC_OFS_FDEC:     rd_mux = DDCC_DATA_W'(fdec_q);
			DDCC_OFS_FSCL:     rd_mux = DDCC_DATA_W'(fscl_q);
			DDCC_OFS_CDEC:     rd_mux = DDCC_DATA_W'(cdec_q);
			DDCC_OFS_CPHASE:   rd_mux = DDCC_DATA_W'(cphase_q);
			DDCC_OFS_CTAPS:    rd_mux = DDCC_DATA_W'(ctaps_q);
			DDCC_OFS_COFS:     rd_mux = DDCC_DATA_W'(cofs_shadow_q);
			DDCC_OFS_CCTL:     rd_mux = DDCC_DATA_W'(cctl_q);
			DDCC_OFS_SIG_I:    rd_mux = map_to_selftest ? DDCC_DATA_W'(sig_i_q) : DDCC_RST_DATA; // RULE17
			DDCC_OFS_SIG_Q:    rd_mux = map_to_selftest ? DDCC_DATA_W'(sig_q_q) : DDCC_RST_DATA; // RULE17
			default:           rd_mux = DDCC_RST_DATA; // Reserved and unused read zero
		endcase
	end

	// Read data registered on the read strobe and held until the next read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ch_rdata <= DDCC_RST_DATA;
		end else if (ch_rd) begin
			ch_rdata <= rd_mux;
		end
	end

endmodule

//--- tb/ddcc_cfg_assertions.sv
// Concurrent checks on the channel configuration ports
`timescale 1ns/1ps
module ddcc_cfg_assertions #(
	parameter int IN_W = 16
) (
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic [7:0]        ch_addr,
	input wire logic [19:0]       ch_wdata,
	input wire logic              ch_wr,
	input wire logic [15:0]       osc_acc_upper,
	input wire logic [15:0]       osc_phase_angle,
	input wire logic [3:0]        sync_pins,
	input wire logic              sync_selected,
	input wire logic              hop_pulse,
	input wire logic              osc_acc_clear,
	input wire logic              phase_dither_en,
	input wire logic              amp_dither_en,
	input wire logic [IN_W-1:0]   adc_a,
	input wire logic [IN_W-1:0]   mixer_i,
	input wire logic [IN_W-1:0]   path_i,
	input wire logic [12:0]       resampler_decimation,
	input wire logic              level_indicator,
	input wire logic [4:0]        resampler_scale_active,
	input wire logic              coef_filter_start,
	input wire logic [7:0]        coef_filter_phase,
	input wire logic              coef_filter_out_strobe,
	input wire logic [7:0]        coef_filter_pointer,
	input wire logic              coefficient_memory_wr_en,
	input wire logic [7:0]        coefficient_memory_wr_addr,
	input wire logic signed [4:0] out_shift
);
	// ------------------------------------------------------------
	// One write to a register, not rewritten on the next edge
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr(a);
		ch_wr && ch_addr == a ##1 !(ch_wr && ch_addr == a);
	endsequence
	// Each check except AST_PHS, AST_PTR and AST_COEFFICIENT_MEMORY ties an output to the value just written
	AST_PHASE: assert property (s_wr(8'h87) |=> osc_phase_angle == $past(osc_acc_upper) + $past(ch_wdata[15:0], 2))
		else $error("phase angle is not accumulator plus offset");
	AST_SYNC: assert property (s_wr(8'h88) |-> sync_selected == sync_pins[$past(ch_wdata[8:7])])
		else $error("wrong sync pin selected");
	AST_HOP: assert property (s_wr(8'h88) ##0 hop_pulse |=> osc_acc_clear == $past(ch_wdata[3], 2))
		else $error("accumulator clear does not follow hop setting");
	AST_DITH: assert property (s_wr(8'h88) |-> {amp_dither_en, phase_dither_en} == $past(ch_wdata[2:1]))
		else $error("dither enables differ from control bits");
	AST_BYP: assert property (s_wr(8'h88) |=> path_i == ($past(ch_wdata[0], 2) ? $past(adc_a) : $past(mixer_i)))
		else $error("I path source wrong for bypass setting");
	AST_RDEC: assert property (s_wr(8'h90) |=> resampler_decimation == $past(ch_wdata[11:0], 2) + 13'h1)
		else $error("resampler decimation is not stored value plus one");
	AST_LI: assert property (s_wr(8'h92) |=> resampler_scale_active ==
		($past(level_indicator) ? $past(ch_wdata[9:5], 2) : $past(ch_wdata[4:0], 2)))
		else $error("resampler scale not chosen by level indicator");
	AST_PHS: assert property (!coef_filter_start |=> $stable(coef_filter_phase))
		else $error("decimation phase changed without a start");
	AST_PTR: assert property (!coef_filter_out_strobe |=> $stable(coef_filter_pointer))
		else $error("coefficient pointer moved without an output sample");
	AST_COEFFICIENT_MEMORY: assert property (ch_wr && !ch_addr[7] |=> coefficient_memory_wr_en && coefficient_memory_wr_addr[6:0] == $past(ch_addr[6:0]))
		else $error("coefficient write not passed on");
	AST_SHIFT: assert property (s_wr(8'hA4) |-> out_shift == $signed({1'b0, $past(ch_wdata[3:0])}) - 5'sh3)
		else $error("output shift is not scale minus three");
endmodule
bind ddcc_channel_cfg ddcc_cfg_assertions #(.IN_W(IN_W)) ddcc_cfg_assertions_i (.*);

//--- tb/testbench.sv
// Self-checking bench of the channel configuration register set
`timescale 1ns/1ps
module testbench import ddcc_pkg::*;;
	// ------------------------------------------------------------
	// Ports and bookkeeping
	// ------------------------------------------------------------
	logic clk, rst_n, ch_wr, ch_rd, hop_pulse, level_indicator, coef_filter_start, coef_filter_out_strobe;
	logic fifth_out_strobe, map_to_selftest, sync_selected, osc_acc_clear, phase_dither_en, amp_dither_en;
	logic coefficient_memory_wr_en, coef_filter_bypass, out_common_exp, out_force_scale, out_use_scale;
	logic [3:0] sync_pins;
	logic [4:0] resampler_scale_active, fifth_order_scale;
	logic signed [4:0] out_shift;
	logic [7:0] ch_addr, coefficient_memory_wr_addr, coef_filter_phase, coef_filter_pointer;
	logic [8:0] fifth_order_decimation, coef_filter_decimation, coef_filter_taps;
	logic [9:0] resampler_interpolation;
	logic [12:0] resampler_decimation;
	logic [15:0] osc_acc_upper, osc_phase_angle, adc_a, adc_b, mixer_i, mixer_q, mixer_in, path_i, path_q;
	logic [15:0] formatted_i, formatted_q;
	logic [19:0] ch_wdata, ch_rdata, coefficient_memory_wr_data, fifth_own_i, fifth_own_q, fifth_ch0_i, fifth_ch0_q;
	logic [19:0] fifth_ch1_i, fifth_ch1_q, coef_in_i, coef_in_q;
	ddcc_fmt_type out_format;
	logic [31:0] seed = 32'h0000_52ED;
	logic [19:0] q[$];
	logic rd_v = 1'b0;
	int n_mismatch = 0, n_checks = 0, cyc = 0;
	// Register addresses and the bits that keep data
	logic [7:0] ad[15] = '{8'h87, 8'h88, 8'h89, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'hA0,
		8'hA1, 8'hA2, 8'hA3, 8'hA4};
	logic [19:0] mk[15] = '{20'h0_FFFF, 20'h0_01CF, 20'h0_0000, 20'h0_0FFF, 20'h0_01FF, 20'h0_03FF,
		20'h0_0000, 20'h0_00FF, 20'h0_001F, 20'h0_0000, 20'h0_00FF, 20'h0_00FF, 20'h0_00FF, 20'h0_00FF, 20'h0_07FF};

	ddcc_channel_cfg ddcc_channel_cfg_i (.*);

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Random datapath inputs, renewed at every rising edge
	initial forever begin
		{osc_acc_upper, adc_a, adc_b, mixer_i, mixer_q, sync_pins, hop_pulse, level_indicator, coef_filter_start,
			coef_filter_out_strobe, fifth_out_strobe, map_to_selftest, fifth_own_i, fifth_own_q, fifth_ch0_i,
			fifth_ch0_q, fifth_ch1_i, fifth_ch1_q, formatted_i, formatted_q}
			<= 242'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
		@(posedge clk);
	end

	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One bus cycle; a read notes its expected data
	task automatic acc(input logic w, r, input logic [7:0] a, input logic [19:0] d, e);
		ch_wr <= w;
		ch_rd <= r;
		ch_addr <= a;
		ch_wdata <= d;
		if (r)
			q.push_back(e);
		@(posedge clk);
	endtask

	// Read data monitor and cycle limit
	always @(posedge clk) begin
		if (rd_v)
			chk({12'h000, ch_rdata}, {12'h000, q.pop_front()});
		rd_v <= ch_rd && rst_n;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			results();
		end
	end

	// Main sequence
	initial begin
		logic [19:0] d;
		ch_wr = 1'b0;
		ch_rd = 1'b0;
		ch_addr = 8'h00;
		ch_wdata = 20'h0_0000;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (ad[i]) acc(1'b0, 1'b1, ad[i], 20'h0_0000, 20'h0_0000);
		repeat (4) foreach (ad[i]) begin
			d = 20'(rnd()) & mk[i];
			d = (ad[i] == 8'h90) ? (d | 20'h0_0800) : d;
			acc(1'b1, 1'b0, ad[i], d, 20'h0_0000);
			acc(1'b0, 1'b1, ad[i], 20'h0_0000, d & mk[i]);
		end
		acc(1'b1, 1'b0, 8'h87, 20'h0_5A5A, 20'h0_0000);
		acc(1'b1, 1'b1, 8'h87, 20'h0_1234, 20'h0_5A5A);
		acc(1'b0, 1'b1, 8'h87, 20'h0_0000, 20'h0_1234);
		acc(1'b1, 1'b0, 8'h90, 20'h0_0FFF, 20'h0_0000);
		acc(1'b1, 1'b0, 8'h91, 20'h0_01FF, 20'h0_0000);
		acc(1'b0, 1'b0, 8'h00, 20'h0_0000, 20'h0_0000);
		#1;
		chk(32'(resampler_decimation), 32'h0000_1000);
		chk(32'(resampler_interpolation), 32'h0000_0200);
		@(posedge clk);
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, 1'b0, 8'hA4, 20'(k % 2 * 256 + k * 20 + 1 + (k == 1) * 64 + (k == 3) * 128), 20'h0_0000);
			acc(1'b1, 1'b0, 8'h05, 20'(k), 20'h0_0000);
			acc(1'b0, 1'b0, 8'h00, 20'h0_0000, 20'h0_0000);
			#1;
			chk(32'(coefficient_memory_wr_addr), 32'(k % 2 * 128 + 5));
			chk(32'(out_format), 32'(k > 1 ? 2 : k));
			chk(32'(out_shift), 32'(4 * k - 2));
			chk(32'(out_use_scale), 32'(k < 2));
			chk(32'(out_common_exp), 32'(k == 3));
			chk(32'(out_force_scale), 32'(k == 1));
			@(posedge clk);
		end
		results();
	end
endmodule
